//--- hw/jie_core.sv
// Decode and execution of the two-word jump and the byte increment.
// What this block does
// - The jump takes two instruction cycles; the second one is a no-operation.
// - Jump literal bits 7..0 from word one, 19..8 from word two, into PC 20..1.
// - Increment reads the byte, adds one, produces the result in one cycle.
// - Destination bit 0 sends the result to W; 1 writes it back to memory.
// - Access bit 0 with extended set on and address up to 95 uses indexed mode.
module jie_core #(
    parameter int ADDR_W = jie_pkg::ADDR_W
) (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic [15:0]              prog_data,
    input  wire logic                     ext_set_en,
    input  wire logic [3:0]               bank_select_register,
    input  wire logic [ADDR_W-1:0]        index_base,
    output logic      [20:0]              prog_addr_q,
    output logic      [7:0]               w_q,
    output logic                          carry_q,
    output logic                          digit_carry_flag_q,
    output logic                          negative_q,
    output logic                          overflow_flag_q,
    output logic                          zero_q,
    output logic                          flush_cycle_q
);

    jie_pkg::jie_phase_e phase_q, phase_d;
    logic [15:0]         ir_q;
    logic [7:0]          klo_q;
    logic [20:0]         pc_q;

    // Program memory is read combinationally from the program counter.
    assign prog_addr_q = pc_q;

    always_comb begin
        case (phase_q)
            jie_pkg::JIE_Q1: phase_d = jie_pkg::JIE_Q2;
            jie_pkg::JIE_Q2: phase_d = jie_pkg::JIE_Q3;
            jie_pkg::JIE_Q3: phase_d = jie_pkg::JIE_Q4;
            jie_pkg::JIE_Q4: phase_d = jie_pkg::JIE_Q1;
            default:         phase_d = jie_pkg::JIE_Q1;
        endcase
    end

    wire        is_q2    = (phase_q == jie_pkg::JIE_Q2);
    wire        is_q4    = (phase_q == jie_pkg::JIE_Q4);
    wire        is_jump  = (ir_q[15:8] == jie_pkg::JUMP_OP1);
    wire        is_inc   = (ir_q[15:10] == jie_pkg::INC_OP);
    wire        dest_f   = ir_q[jie_pkg::D_BIT];
    wire        bank_sel = ir_q[jie_pkg::A_BIT];
    wire [7:0]  f_addr   = ir_q[7:0];

    // The second word is taken as it stands; its prefix nibble is not checked.
    wire [19:0] jump_k   = {prog_data[11:0], klo_q};
    wire [20:0] jump_pc  = {jump_k, 1'b0};
    wire [20:0] pc_next  = pc_q + 21'h00_0002;

    // Address selection for the byte operand.
    wire        indexed  = !bank_sel && ext_set_en && (f_addr <= jie_pkg::INDEX_MAX);
    wire [3:0]  acc_bank = (f_addr < jie_pkg::ACCESS_SPLIT) ? jie_pkg::ACCESS_LO
                                                            : jie_pkg::ACCESS_HI;
    wire [ADDR_W-1:0] idx_addr = ADDR_W'(index_base + ADDR_W'(f_addr));
    wire [ADDR_W-1:0] bank_addr = ADDR_W'({bank_sel ? bank_select_register : acc_bank,
                                           f_addr});
    wire [ADDR_W-1:0] mem_addr = indexed ? idx_addr : bank_addr;

    wire [7:0]  rdata;
    wire [8:0]  sum9     = {1'b0, rdata} + 9'h001;
    wire [7:0]  sum      = sum9[7:0];
    wire        nib_carry = (rdata[3:0] == 4'hF);
    wire        ovf_out  = (rdata == 8'h7F);
    wire        inc_wr   = is_q4 && is_inc;
    wire        mem_we   = inc_wr && dest_f;
    wire        jump_go  = is_q4 && is_jump;

    // Operand is read in Q2 and written back at the end of Q4 of the same cycle.
    jie_data_mem #(
        .ADDR_W (ADDR_W)
    ) u_mem (
        .clk    (clk),
        .addr   (mem_addr),
        .we     (mem_we),
        .wdata  (sum),
        .rdata_q (rdata)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_q <= jie_pkg::JIE_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Fetch and program counter; a taken jump flushes the word already fetched.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc_q          <= jie_pkg::PC_RST;
            ir_q          <= jie_pkg::NOP_WORD;
            flush_cycle_q <= 1'b0;
        end else if (is_q4) begin
            if (is_jump) begin
                pc_q          <= jump_pc;
                ir_q          <= jie_pkg::NOP_WORD;
                flush_cycle_q <= 1'b1;
            end else begin
                pc_q          <= pc_next;
                ir_q          <= prog_data;
                flush_cycle_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            klo_q <= 8'h00;
        end else if (is_q2 && is_jump) begin
            klo_q <= ir_q[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            w_q <= jie_pkg::W_RST;
        end else if (inc_wr && !dest_f) begin
            w_q <= sum;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            carry_q            <= 1'b0;
            digit_carry_flag_q <= 1'b0;
            negative_q         <= 1'b0;
            overflow_flag_q    <= 1'b0;
            zero_q             <= 1'b0;
        end else if (inc_wr) begin
            carry_q            <= sum9[8];
            digit_carry_flag_q <= nib_carry;
            negative_q         <= sum[7];
            overflow_flag_q    <= ovf_out;
            zero_q             <= (sum == 8'h00);
        end
    end

    // Checks.
    property p_jump_pc;
        @(posedge clk) disable iff (reset)
        jump_go |=> pc_q == $past(jump_pc);
    endproperty
    a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

    property p_jump_nop;
        @(posedge clk) disable iff (reset)
        jump_go |=> (flush_cycle_q && !mem_we && !is_jump && !is_inc)[*4];
    endproperty
    a_jump_nop: assert property (p_jump_nop) else $error("jump second cycle not idle");

    property p_jump_fetch;
        @(posedge clk) disable iff (reset)
        jump_go |=> ##3 (pc_q == $past(jump_pc, 4));
    endproperty
    a_jump_fetch: assert property (p_jump_fetch) else $error("refetch moved pc");

    property p_inc_w;
        @(posedge clk) disable iff (reset)
        (inc_wr && !dest_f) |=> w_q == $past(rdata) + 8'h01;
    endproperty
    a_inc_w: assert property (p_inc_w) else $error("W not incremented");

    property p_dest_mem;
        @(posedge clk) disable iff (reset)
        (inc_wr && dest_f) |-> mem_we ##1 $stable(w_q);
    endproperty
    a_dest_mem: assert property (p_dest_mem) else $error("file destination wrong");

    property p_indexed;
        @(posedge clk) disable iff (reset)
        (is_inc && !bank_sel && ext_set_en && f_addr <= 8'h5F)
            |-> mem_addr == ADDR_W'(index_base + ADDR_W'(f_addr));
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_bank_sel;
        @(posedge clk) disable iff (reset)
        (is_inc && bank_sel) |-> mem_addr == ADDR_W'({bank_select_register, f_addr});
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank address wrong");

    property p_access_bank;
        @(posedge clk) disable iff (reset)
        (is_inc && !bank_sel && !(ext_set_en && f_addr <= jie_pkg::INDEX_MAX))
            |-> mem_addr == ADDR_W'({(f_addr < 8'h60) ? 4'h0 : 4'hF, f_addr});
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

    property p_flags;
        @(posedge clk) disable iff (reset)
        inc_wr |=> (zero_q == ($past(rdata) == 8'hFF)) && (carry_q == zero_q)
                   && (overflow_flag_q == ($past(rdata) == 8'h7F));
    endproperty
    a_flags: assert property (p_flags) else $error("status flags wrong");

    // The design takes the nibble flag from the operand and the sign flag from the adder; both are checked against the operand.
    property p_flags_nd;
        @(posedge clk) disable iff (reset)
        inc_wr |=> (digit_carry_flag_q == (($past(rdata) & 8'h0F) == 8'h0F))
                   && (negative_q == (($past(rdata) >= 8'h7F) && ($past(rdata) != 8'hFF)));
    endproperty
    a_flags_nd: assert property (p_flags_nd) else $error("nibble or sign flag wrong");

    property p_phase_walk;
        @(posedge clk) disable iff (reset)
        is_q4 |=> (phase_q == jie_pkg::JIE_Q1) ##1 (phase_q == jie_pkg::JIE_Q2)
                  ##1 (phase_q == jie_pkg::JIE_Q3) ##1 is_q4;
    endproperty
    a_phase_walk: assert property (p_phase_walk) else $error("phase order wrong");

    property p_pc_stand;
        @(posedge clk) disable iff (reset)
        !is_q4 |=> $stable(pc_q);
    endproperty
    a_pc_stand: assert property (p_pc_stand) else $error("pc moved outside q4");

    property p_flush_end;
        @(posedge clk) disable iff (reset)
        (is_q4 && flush_cycle_q) |=> !flush_cycle_q && (pc_q == $past(pc_q) + 21'h00_0002);
    endproperty
    a_flush_end: assert property (p_flush_end) else $error("refill cycle wrong");

endmodule : jie_core

//--- hw/jie_data_mem.sv
// Byte-wide data memory with registered read data.
module jie_data_mem #(
    parameter int ADDR_W = jie_pkg::ADDR_W
) (
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              we,
    input  wire logic [7:0]        wdata,
    output logic      [7:0]        rdata_q
);

    logic [7:0] mem [2**ADDR_W];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end

endmodule : jie_data_mem

//--- hw/jie_pkg.sv
// Shared constants for the jump and increment execution block.
package jie_pkg;

    localparam int          PC_W          = 21;
    localparam int          WORD_W        = 16;
    localparam int          ADDR_W        = 12;
    localparam int          BANK_W        = 4;

    // Instruction encodings.
    localparam logic [7:0]  JUMP_OP1      = 8'hEF;
    localparam logic [3:0]  JUMP_OP2      = 4'hF;
    localparam logic [5:0]  INC_OP        = 6'h0A;
    localparam logic [15:0] NOP_WORD      = 16'h0000;

    // Instruction field positions.
    localparam int          D_BIT         = 9;
    localparam int          A_BIT         = 8;

    // Access bank and indexed literal offset boundaries.
    localparam logic [7:0]  INDEX_MAX     = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [3:0]  ACCESS_HI     = 4'hF;
    localparam logic [3:0]  ACCESS_LO     = 4'h0;

    // Reset values.
    localparam logic [20:0] PC_RST        = 21'h00_0000;
    localparam logic [7:0]  W_RST         = 8'h00;

    // Four phases of each instruction cycle, Gray coded.
    typedef enum logic [1:0] {
        JIE_Q1 = 2'b00,
        JIE_Q2 = 2'b01,
        JIE_Q3 = 2'b11,
        JIE_Q4 = 2'b10
    } jie_phase_e;

endpackage : jie_pkg

//--- tb/jie_prog_mem_model.sv
// Program memory model that answers word reads combinationally.
module jie_prog_mem_model (
    input  wire logic [20:0] prog_addr,
    output logic      [15:0] prog_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // The bench fills every word before reset ends; one owner avoids a start-up race.
    logic [15:0] mem [0:4095];
    // Only 12 address bits (12..1) decode, so high jump targets alias and still fetch words.
    assign prog_data = mem[prog_addr[12:1]];
endmodule : jie_prog_mem_model

//--- tb/tb.sv
// Self-checking bench for the jump and increment execution block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [20:0] BASE = 21'h1E_B480;
    logic        clk, reset, ext_set_en;
    logic [3:0]  bank_select_register;
    logic [11:0] index_base;
    logic [15:0] prog_data;
    logic [20:0] prog_addr_q;
    logic [7:0]  w_q;
    logic        carry_q, digit_carry_flag_q, negative_q, overflow_flag_q, zero_q;
    logic        flush_cycle_q;
    logic [4:0]  flags;
    int          num_errors, checks, ix;
    assign flags = {carry_q, digit_carry_flag_q, negative_q, overflow_flag_q, zero_q};
    initial clk = 1'b0;
    always #2 clk = ~clk;
    jie_core dut_u (.clk(clk), .reset(reset), .prog_data(prog_data),
        .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
        .index_base(index_base), .prog_addr_q(prog_addr_q), .w_q(w_q),
        .carry_q(carry_q), .digit_carry_flag_q(digit_carry_flag_q),
        .negative_q(negative_q), .overflow_flag_q(overflow_flag_q),
        .zero_q(zero_q), .flush_cycle_q(flush_cycle_q));
    jie_prog_mem_model pm_u (.prog_addr(prog_addr_q), .prog_data(prog_data));
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic put(input logic [15:0] word, input int count);
        repeat (count) begin
            pm_u.mem[ix] = word;
            ix++;
        end
    endtask : put
    task automatic wait_pc(input logic [20:0] a);
        int n;
        n = 0;
        while (prog_addr_q !== a && n < 4000) begin
            tick();
            n++;
        end
        check("pc reached", prog_addr_q, a);
    endtask : wait_pc
    // Results of word i land as the counter moves two words past it.
    task automatic exp_at(input int i, input logic [7:0] w, input logic [4:0] f);
        wait_pc(BASE + 21'(2 * (i + 2)));
        check("w", 21'(w_q), 21'(w));
        check("flags", 21'(flags), 21'(f));
    endtask : exp_at
    initial begin
        int n;
        reset = 1'b1;
        ext_set_en = 1'b0;
        bank_select_register = 4'h1;
        index_base = 12'hFB1;
        num_errors = 0;
        checks = 0;
        ix = 0;
        // Data memory has no reset, so both memories are cleared before the run.
        for (int i = 0; i < 4096; i++) begin
            pm_u.mem[i] = 16'h0000;
            dut_u.u_mem.mem[i] = 8'h00;
        end
        put(16'hEF40, 1);
        put(16'hFF5A, 1);
        ix = 32'h0000_0A40;
        put(16'h2810, 1);
        put(16'h0000, 1);
        put(16'h2A10, 127);
        put(16'h2810, 1);
        put(16'h0000, 1);
        put(16'h2A10, 128);
        put(16'h2810, 1);
        put(16'h0000, 1);
        put(16'h2910, 1);
        put(16'h0000, 2);
        put(16'h285F, 1);
        put(16'h0000, 1);
        put(16'h2A3F, 1);
        put(16'h28F0, 1);
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        tick();
        check("pc after reset", prog_addr_q, 21'h00_0000);
        n = 0;
        while (flush_cycle_q !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        check("jump target", prog_addr_q, BASE);
        repeat (3) tick();
        check("flush held", 21'(flush_cycle_q), 21'h00_0001);
        tick();
        check("flush ended", 21'(flush_cycle_q), 21'h00_0000);
        check("pc after flush", prog_addr_q, BASE + 21'h00_0002);
        $display("test jump done");
        exp_at(0, 8'h01, 5'h00);
        exp_at(129, 8'h80, 5'h0E);
        exp_at(259, 8'h00, 5'h19);
        $display("test increment done");
        exp_at(261, 8'h01, 5'h00);
        @(posedge clk);
        ext_set_en <= 1'b1;
        exp_at(264, 8'h00, 5'h19);
        // Indexed write to the top access bank, then a read of it through the access bank.
        exp_at(267, 8'h02, 5'h00);
        $display("test addressing done");
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule : tb
